// [logic/isle_pkg.sv]
package isle_pkg;

    localparam int unsigned WORD_W = 14;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned IDX_W  = 7;
    localparam int unsigned PC_W   = 13;
    localparam int unsigned REG_N  = 128;

    // instruction word fields
    localparam int unsigned OPC6_LSB = 8;
    localparam int unsigned OPC4_LSB = 10;
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned IDX_LSB  = 0;
    localparam int unsigned LIT_LSB  = 0;

    // opcodes, upper six or four bits of the word
    localparam logic [5:0] OPC_INCR_SKIP = 6'h0f;
    localparam logic [5:0] OPC_OR_LIT    = 6'h38;
    localparam logic [5:0] OPC_OR_REG    = 6'h04;
    localparam logic [3:0] OPC_LOAD_LIT  = 4'hc;

    // destination bit values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // values after reset, plus pc step, increment and zero constants
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic              ZERO_RST = 1'b0;
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP  = 13'h0001;
    localparam logic [DATA_W-1:0] INCR_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    typedef enum logic [2:0] {
        OP_IDLE       = 3'h0,
        OP_INCR_SKIP  = 3'h1,
        OP_OR_LIT     = 3'h2,
        OP_LOAD_LIT   = 3'h3,
        OP_OR_REG     = 3'h4
    } isle_op_t;

    // gray codes along execute -> discard -> execute
    typedef enum logic [1:0] {
        ST_EXEC    = 2'b00,
        ST_DISCARD = 2'b01
    } isle_state_t;

endpackage

// [logic/isle_dec_if.sv]
`timescale 1ns/1ps
interface isle_dec_if;
    import isle_pkg::*;

    logic [WORD_W-1:0] word;
    isle_op_t          op;
    logic              dest;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] literal;

    modport dec
    (
        input  word,
        output op,
        output dest,
        output idx,
        output literal
    );
    modport exe
    (
        output word,
        input  op,
        input  dest,
        input  idx,
        input  literal
    );
endinterface

// [logic/isle_decoder.sv]
`timescale 1ns/1ps
module isle_decoder
    import isle_pkg::*;
(
    isle_dec_if.dec d
);
    wire [5:0] opc6 = d.word[OPC6_LSB +: 6];
    wire [3:0] opc4 = d.word[OPC4_LSB +: 4];

    wire hit_incr = (opc6 == OPC_INCR_SKIP);
    wire hit_orl  = (opc6 == OPC_OR_LIT);
    wire hit_orr  = (opc6 == OPC_OR_REG);
    wire hit_load = (opc4 == OPC_LOAD_LIT);

    // anything else is executed as an idle cycle
    assign d.op = hit_incr ? OP_INCR_SKIP :
                  hit_orl  ? OP_OR_LIT    :
                  hit_orr  ? OP_OR_REG    :
                  hit_load ? OP_LOAD_LIT  : OP_IDLE;

    assign d.dest    = d.word[DEST_BIT];
    assign d.idx     = d.word[IDX_LSB +: IDX_W];
    assign d.literal = d.word[LIT_LSB +: DATA_W];
endmodule

// [logic/isle_core.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - increment-skip adds one to the register, leaves all flags alone
// - destination bit 0 writes accumulator, 1 writes back to register
// - increment-skip result zero: discard fetched word, run idle cycle
// - increment-skip result nonzero: continue at next address, one cycle
// - or-immediate ORs literal into accumulator, updates zero flag
// - load-immediate copies literal to accumulator, flags untouched
// - load-immediate don't-care bits come as zero, decoder ignores them
// - or-with-register ORs accumulator and register, routes, updates zero
module isle_core
    import isle_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire logic [WORD_W-1:0] instr_word,
    input  wire logic              load_en,
    input  wire logic [IDX_W-1:0]  load_addr,
    input  wire logic [DATA_W-1:0] load_data,
    output logic [DATA_W-1:0]      acc,
    output logic                   zero_flag,
    output logic [PC_W-1:0]        pc,
    output logic                   skip_active,
    output logic                   discarded,
    output logic                   unsupported,
    output logic                   reg_wr_en,
    output logic [IDX_W-1:0]       reg_wr_addr,
    output logic [DATA_W-1:0]      reg_wr_data
);
    ////////////////////////////////////////////////////////////////////////////
    isle_dec_if dif ();
    isle_decoder u_dec
    (
        .d (dif.dec)
    );
    assign dif.word = instr_word;

    logic [DATA_W-1:0] regs [REG_N];
    isle_state_t       state;

    ////////////////////////////////////////////////////////////////////////////
    wire               run       = instr_valid && (state == ST_EXEC);
    wire               drop      = instr_valid && (state == ST_DISCARD);
    wire [DATA_W-1:0]  rd_data   = regs[dif.idx];
    wire               is_incr   = run && (dif.op == OP_INCR_SKIP);
    wire               is_orl    = run && (dif.op == OP_OR_LIT);
    wire               is_load   = run && (dif.op == OP_LOAD_LIT);
    wire               is_orr    = run && (dif.op == OP_OR_REG);
    wire               reg_op    = is_incr || is_orr;

    wire [DATA_W-1:0]  incr_res  = DATA_W'(rd_data + INCR_ONE);
    wire [DATA_W-1:0]  orr_res   = acc | rd_data;
    wire [DATA_W-1:0]  orl_res   = acc | dif.literal;
    wire [DATA_W-1:0]  result    = is_incr ? incr_res :
                                   is_orr  ? orr_res  :
                                   is_orl  ? orl_res  : dif.literal;

    wire               to_reg    = reg_op && (dif.dest == DEST_REG);
    wire               to_acc    = (reg_op && (dif.dest == DEST_ACC))
                                   || is_orl || is_load;
    // zero test on the 8-bit result
    wire               res_zero  = (result == DATA_ZERO);
    // only the OR forms touch the flag
    wire               upd_zero  = is_orl || is_orr;
    wire               take_skip = is_incr && res_zero;

    wire [DATA_W-1:0]  next_acc   = to_acc ? result : acc;
    wire               next_zero  = upd_zero ? res_zero : zero_flag;
    wire [PC_W-1:0]    next_pc    = instr_valid ? PC_W'(pc + PC_STEP) : pc;
    isle_state_t       next_state;

    always_comb
    begin
        case (state)
            ST_EXEC:
                next_state = take_skip ? ST_DISCARD : ST_EXEC;
            ST_DISCARD:
                next_state = instr_valid ? ST_EXEC : ST_DISCARD;
            default:
                next_state = ST_EXEC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag untouched unless upd_zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            acc       <= ACC_RST;
            zero_flag <= ZERO_RST;
            pc        <= PC_RST;
            state     <= ST_EXEC;
        end
        else
        begin
            acc       <= next_acc;
            zero_flag <= next_zero;
            pc        <= next_pc;
            state     <= next_state;
        end
    end

    // nonzero result keeps the pipe in execute
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            skip_active <= 1'b0;
            discarded   <= 1'b0;
            unsupported <= 1'b0;
        end
        else
        begin
            skip_active <= (next_state == ST_DISCARD);
            discarded   <= drop;
            unsupported <= run && (dif.op == OP_IDLE);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_wr_en   <= 1'b0;
            reg_wr_addr <= {IDX_W{1'b0}};
            reg_wr_data <= DATA_ZERO;
        end
        else
        begin
            reg_wr_en   <= to_reg;
            reg_wr_addr <= dif.idx;
            reg_wr_data <= result;
        end
    end

    // no reset on the array; preload has priority over execution writes
    always_ff @(posedge ref_clk)
    begin
        if (load_en)
            regs[load_addr] <= load_data;
        else if (to_reg)
            regs[dif.idx] <= result;
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence incr_zero_s;
        is_incr && (incr_res == DATA_ZERO);
    endsequence
    sequence next_fetch_s;
        instr_valid;
    endsequence

    incr_value_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        is_incr && dif.dest && !load_en |=> reg_wr_en
        && reg_wr_data == DATA_W'($past(rd_data) + INCR_ONE))
        else $error("increment result wrong");
    incr_flags_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        is_incr |=> $stable(zero_flag))
        else $error("increment changed the zero flag");
    dest_route_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        reg_op && !dif.dest |=> !reg_wr_en && acc == $past(result))
        else $error("destination 0 did not go to accumulator");
    skip_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        incr_zero_s ##1 next_fetch_s |=> discarded && $stable(acc)
        && $stable(zero_flag) && !reg_wr_en && !skip_active)
        else $error("skipped word was not discarded");
    no_skip_a: assert property (@(posedge ref_clk) disable iff (rst)
        is_incr && incr_res != DATA_ZERO |=> !skip_active
        && pc == $past(pc) + PC_STEP)
        else $error("nonzero increment skipped");
    or_literal_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        is_orl |=> acc == ($past(acc) | $past(dif.literal)))
        else $error("or-immediate result wrong");
    load_lit_a: assert property (@(posedge ref_clk) disable iff (rst)
        is_load |=> acc == $past(dif.literal) && $stable(zero_flag))
        else $error("load-immediate result wrong");
    dont_care_a: assert property (@(posedge ref_clk) disable iff (rst)
        instr_word[13:10] == OPC_LOAD_LIT |-> dif.op == OP_LOAD_LIT)
        else $error("load-immediate not decoded");
    or_register_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        is_orr |=> $past(orr_res) == ($past(dif.dest) ? reg_wr_data : acc))
        else $error("or-with-register result wrong");
    zero_update_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        upd_zero |=> zero_flag == ($past(result) == DATA_ZERO))
        else $error("zero flag does not match result");
endmodule

// [tb/test_incr_skip_or_literal_exec.sv]
`timescale 1ns/1ps
module test_incr_skip_or_literal_exec;
    import isle_pkg::*;

    typedef struct {
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] acc_in;
        logic [DATA_W-1:0] reg_in;
        logic              zero_in;
        logic [DATA_W-1:0] acc_exp;
        logic              zero_exp;
        logic              wr_exp;
        logic [DATA_W-1:0] wr_data;
        logic              skip_exp;
    } isle_row_t;

    logic              ref_clk;
    logic              rst;
    logic              instr_valid;
    logic [WORD_W-1:0] instr_word;
    logic              load_en;
    logic [IDX_W-1:0]  load_addr;
    logic [DATA_W-1:0] load_data;
    logic [DATA_W-1:0] acc;
    logic              zero_flag;
    logic [PC_W-1:0]   pc;
    logic              skip_active;
    logic              discarded;
    logic              unsupported;
    logic              reg_wr_en;
    logic [IDX_W-1:0]  reg_wr_addr;
    logic [DATA_W-1:0] reg_wr_data;
    logic [PC_W-1:0]   exp_pc;
    int                error_cnt;
    int                check_count;
    int                cycles;

    // word, acc in, reg 5, zero in, acc out, zero out, write, data, skip
    isle_row_t rows [10] = '{
        '{14'h0f85, 8'h12, 8'h41, 1'h1, 8'h12, 1'h1, 1'h1, 8'h42, 1'h0},
        '{14'h0f85, 8'h12, 8'hff, 1'h0, 8'h12, 1'h0, 1'h1, 8'h00, 1'h1},
        '{14'h0f05, 8'h12, 8'h7f, 1'h1, 8'h80, 1'h1, 1'h0, 8'h00, 1'h0},
        '{14'h0f05, 8'h12, 8'hff, 1'h0, 8'h00, 1'h0, 1'h0, 8'h00, 1'h1},
        '{14'h3835, 8'h9a, 8'h00, 1'h1, 8'hbf, 1'h0, 1'h0, 8'h00, 1'h0},
        '{14'h3800, 8'h00, 8'h00, 1'h0, 8'h00, 1'h1, 1'h0, 8'h00, 1'h0},
        '{14'h305a, 8'h00, 8'h00, 1'h1, 8'h5a, 1'h1, 1'h0, 8'h00, 1'h0},
        '{14'h335a, 8'h00, 8'h00, 1'h0, 8'h5a, 1'h0, 1'h0, 8'h00, 1'h0},
        '{14'h0405, 8'h91, 8'h13, 1'h1, 8'h93, 1'h0, 1'h0, 8'h00, 1'h0},
        '{14'h0485, 8'h80, 8'h01, 1'h1, 8'h80, 1'h0, 1'h1, 8'h81, 1'h0}
    };

    isle_core DUT (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .instr_valid (instr_valid),
        .instr_word  (instr_word),
        .load_en     (load_en),
        .load_addr   (load_addr),
        .load_data   (load_data),
        .acc         (acc),
        .zero_flag   (zero_flag),
        .pc          (pc),
        .skip_active (skip_active),
        .discarded   (discarded),
        .unsupported (unsupported),
        .reg_wr_en   (reg_wr_en),
        .reg_wr_addr (reg_wr_addr),
        .reg_wr_data (reg_wr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // a hang shows as a count running out, not as a silent stall
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // drives land 1 ns after the edge, results read 1 ns after the next;
    // valid stays up so back to back words never toggle it in one step
    task automatic issue(input logic [WORD_W-1:0] w);
        instr_valid = 1'h1;
        instr_word  = w;
        @(posedge ref_clk);
        #1;
        exp_pc      = exp_pc + PC_STEP;
    endtask

    task automatic preload(input logic [IDX_W-1:0] a, input logic [7:0] v);
        instr_valid = 1'h0;
        load_en   = 1'h1;
        load_addr = a;
        load_data = v;
        @(posedge ref_clk);
        #1;
        load_en = 1'h0;
    endtask

    task automatic do_reset();
        rst = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        rst    = 1'h0;
        exp_pc = PC_RST;
        chk_val(acc, 16'h0000);
        chk_bit(zero_flag, 1'h0);
        chk_val(pc, 16'h0000);
        chk_bit(skip_active, 1'h0);
        chk_bit(reg_wr_en, 1'h0);
        $display("reset test done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {instr_valid, instr_word, load_en, load_addr, load_data} = '0;
        {error_cnt, check_count, cycles} = '0;
        exp_pc = PC_RST;
        do_reset();
        foreach (rows[i])
        begin
            preload(7'h05, rows[i].reg_in);
            // zero flag forced to a known level, then acc loaded
            issue({4'hc, 2'h0, 7'h00, ~rows[i].zero_in});
            issue({OPC_OR_LIT, 8'h00});
            issue({OPC_LOAD_LIT, 2'h0, rows[i].acc_in});
            issue(rows[i].word);
            chk_val(acc, rows[i].acc_exp);
            chk_bit(zero_flag, rows[i].zero_exp);
            chk_bit(reg_wr_en, rows[i].wr_exp);
            if (rows[i].wr_exp)
            begin
                chk_val(reg_wr_data, rows[i].wr_data);
                chk_val(reg_wr_addr, 16'h0005);
            end
            chk_bit(skip_active, rows[i].skip_exp);
            chk_val(pc, exp_pc);
            if (rows[i].skip_exp)
            begin
                issue({OPC_LOAD_LIT, 2'h0, 8'h77});
                chk_bit(discarded, 1'h1);
                chk_val(acc, rows[i].acc_exp);
            end
            $display("row %0d test done", i);
        end
        // back to back: the word right behind a skip must not run
        preload(7'h09, 8'hff);
        issue(14'h3011);
        issue(14'h0f89);
        issue(14'h38f0);
        chk_bit(discarded, 1'h1);
        chk_val(acc, 16'h0011);
        issue(14'h3800);
        chk_bit(discarded, 1'h0);
        chk_val(pc, exp_pc);
        $display("back to back skip test done");
        // skip held across a gap in valid words
        preload(7'h09, 8'hff);
        issue(14'h0f09);
        instr_valid = 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk_bit(skip_active, 1'h1);
        chk_val(pc, exp_pc);
        issue(14'h3055);
        chk_bit(discarded, 1'h1);
        chk_val(acc, 16'h0000);
        $display("skip gap test done");
        issue(14'h2000);
        chk_bit(unsupported, 1'h1);
        chk_val(acc, 16'h0000);
        chk_val(pc, exp_pc);
        $display("unknown opcode test done");
        instr_valid = 1'h0;
        do_reset();
        finish_test();
    end
endmodule
